/* File: logic/hxip_pkg.sv */
/*
 holds the constants of the host exchange and interrupt port:
 register offsets, field positions, reset values, command codes, states.
 assumes one aligned 32-bit word per register on an AHB-Lite bus.
*/
`default_nettype none
package hxip_pkg;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [8:0] OFF_CMD = 9'h000;
	localparam logic [8:0] OFF_CFG = 9'h004;
	localparam logic [8:0] OFF_MON = 9'h008;
	localparam logic [8:0] OFF_PUT = 9'h00C;
	localparam logic [8:0] OFF_GET = 9'h010;
	localparam logic [8:0] OFF_IRQ = 9'h014;
	localparam logic [8:0] OFF_STAT = 9'h018;
	localparam int SM_SEL_BIT = 8;
	localparam int SM_AW = 6;
	localparam int SM_DEPTH = 64;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CMD_CNT_LSB = 8;
	localparam int CFG_HNUM_LSB = 0;
	localparam int CFG_MAX_LSB = 8;
	localparam int CFG_HVAL_BIT = 16;
	localparam int CFG_IEN_BIT = 17;
	localparam int MON_HI_LSB = 16;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_PEND_BIT = 8;
	localparam int ST_STALL_BIT = 4;
	localparam int ST_BUSY_BIT = 5;
	localparam int ST_SUBD_BIT = 6;
	localparam int ST_FAIL_BIT = 7;
	localparam int ST_REM_LSB = 8;
	localparam int ST_RDREQ_BIT = 14;
	localparam int ST_WRREQ_BIT = 15;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] MAX_RST = 8'h7F;
	localparam logic [7:0] HNUM_RST = 8'h00;
	localparam logic IEN_RST = 1'b1;
	// ------------------------------------------------------------
	// commands and states
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		C_NONE = 4'h0,
		C_QWR = 4'h1,
		C_QRD = 4'h2,
		C_DRD = 4'h3,
		C_DWR = 4'h4,
		C_TRD = 4'h5,
		C_TWR = 4'h6,
		C_PUT = 4'h7,
		C_GET = 4'h8
	} hxip_cmd_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_Q_REF = 3'b001,
		ST_Q_WAIT = 3'b010,
		ST_D_XFER = 3'b011,
		ST_T_WAIT = 3'b100,
		ST_T_REF = 3'b101,
		ST_T_END = 3'b110,
		ST_P_REF = 3'b111
	} hxip_state_t;
endpackage
`default_nettype wire

/* File: logic/hxip_sm_if.sv */
/*
 one port of the shared memory: write strobe, addresses, data.
 assumes the memory answers reads without a clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface hxip_sm_if;
	logic we;
	logic [5:0] waddr;
	logic [5:0] raddr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport mem (input we, input waddr, input raddr, input wdata, output rdata);
	modport cli (output we, output waddr, output raddr, output wdata, input rdata);
endinterface
`default_nettype wire

/* File: logic/hxip_shmem.sv */
/*
 dual-port shared memory between host and module program.
 assumes both ports on hclk; the host port wins a same-word write clash.
*/
`timescale 1ns/1ns
`default_nettype none
module hxip_shmem (
	input wire logic clk,
	hxip_sm_if.mem pa,
	hxip_sm_if.mem pb
);
	logic [15:0] mem [0:hxip_pkg::SM_DEPTH-1];

	// ------------------------------------------------------------
	// writes, host first
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (pb.we)
		begin
			mem[pb.waddr] <= pb.wdata;
		end
		if (pa.we && !(pb.we && pb.waddr == pa.waddr))
		begin
			mem[pa.waddr] <= pa.wdata;
		end
	end

	assign pa.rdata = mem[pa.raddr];
	assign pb.rdata = mem[pb.raddr];
endmodule
`default_nettype wire

/* File: logic/hxip_top.sv */
/*
 host exchange and interrupt port: queued, direct, triggered and
 single-word transfers at i/o refresh, shared memory, host interrupts.
 assumes backplane pins are asynchronous and stable before their strobes.
*/
// The address map and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module hxip_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic bp_refresh,
	input wire logic bp_irq_bit,
	input wire logic [7:0] bp_irq_num,
	input wire logic bp_cc_stb,
	input wire logic [7:0] bp_cc_num,
	input wire logic bp_fd_done,
	input wire logic bp_trig,
	input wire logic bp_sm_wr,
	input wire logic [5:0] bp_sm_addr,
	input wire logic [15:0] bp_sm_wdata,
	input wire logic [15:0] bp_in_word,
	output logic [15:0] bp_sm_rdata,
	output logic [15:0] bp_put_word,
	output logic [15:0] bp_mon_lo,
	output logic [15:0] bp_mon_hi,
	output logic bp_host_rd_req,
	output logic bp_host_wr_req,
	output logic bp_irq_fail,
	output logic bp_busy,
	output logic bp_sub_done
);
	localparam int SW = 60;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// ------------------------------------------------------------
	// pin synchronisers and edge detect
	// ------------------------------------------------------------
	logic [SW-1:0] sy1_reg;
	logic [SW-1:0] sy2_reg;
	logic [5:0] prev_reg;
	logic [5:0] rise;
	logic ref_ev, ibit_ev, cc_ev, fd_ev, trig_ev, smw_ev;
	logic [7:0] s_irq_num, s_cc_num;
	logic [5:0] s_sm_addr;
	logic [15:0] s_sm_wdata, s_in_word;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sy1_reg <= '0;
			sy2_reg <= '0;
			prev_reg <= '0;
		end
		else
		begin
			sy1_reg <= {bp_refresh, bp_irq_bit, bp_cc_stb, bp_fd_done, bp_trig, bp_sm_wr,
				bp_irq_num, bp_cc_num, bp_sm_addr, bp_sm_wdata, bp_in_word};
			sy2_reg <= sy1_reg;
			prev_reg <= sy2_reg[59:54];
		end
	end

	assign rise = sy2_reg[59:54] & ~prev_reg;
	assign {ref_ev, ibit_ev, cc_ev, fd_ev, trig_ev, smw_ev} = rise;
	assign {s_irq_num, s_cc_num, s_sm_addr, s_sm_wdata, s_in_word} = sy2_reg[53:0];

	// ------------------------------------------------------------
	// ahb-lite slave, zero wait states
	// ------------------------------------------------------------
	logic acc;
	logic dp_wr_reg;
	logic [8:0] dp_addr_reg;
	logic wr_cmd, wr_cfg, wr_mon, wr_put, wr_irq;
	logic [31:0] rd_mux;

	assign acc = hsel && hready && htrans[1];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_wr_reg <= 1'b0;
			dp_addr_reg <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= '0;
		end
		else
		begin
			dp_wr_reg <= acc && hwrite;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (acc)
			begin
				dp_addr_reg <= haddr[8:0];
			end
			hrdata <= (acc && !hwrite) ? rd_mux : '0;
		end
	end

	assign wr_cmd = dp_wr_reg && dp_addr_reg == hxip_pkg::OFF_CMD;
	assign wr_cfg = dp_wr_reg && dp_addr_reg == hxip_pkg::OFF_CFG;
	assign wr_mon = dp_wr_reg && dp_addr_reg == hxip_pkg::OFF_MON;
	assign wr_put = dp_wr_reg && dp_addr_reg == hxip_pkg::OFF_PUT;
	assign wr_irq = dp_wr_reg && dp_addr_reg == hxip_pkg::OFF_IRQ;

	// ------------------------------------------------------------
	// shared memory, both ports immediate
	// ------------------------------------------------------------
	hxip_sm_if smp_a ();
	hxip_sm_if smp_b ();

	assign smp_a.we = dp_wr_reg && dp_addr_reg[hxip_pkg::SM_SEL_BIT];
	assign smp_a.waddr = dp_addr_reg[7:2];
	assign smp_a.raddr = haddr[7:2];
	assign smp_a.wdata = hwdata[15:0];
	assign smp_b.we = smw_ev;
	assign smp_b.waddr = s_sm_addr;
	assign smp_b.raddr = s_sm_addr;
	assign smp_b.wdata = s_sm_wdata;

	hxip_shmem u_shmem (
		.clk(hclk),
		.pa(smp_a.mem),
		.pb(smp_b.mem)
	);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bp_sm_rdata <= '0;
		end
		else
		begin
			bp_sm_rdata <= smp_b.rdata;
		end
	end

	// ------------------------------------------------------------
	// software settings
	// ------------------------------------------------------------
	logic [7:0] max_reg, hnum_reg;
	logic hval_reg, ien_reg;
	logic [15:0] put_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			max_reg <= hxip_pkg::MAX_RST;
			hnum_reg <= hxip_pkg::HNUM_RST;
			hval_reg <= 1'b0;
			ien_reg <= hxip_pkg::IEN_RST;
			put_reg <= '0;
			bp_mon_lo <= '0;
			bp_mon_hi <= '0;
		end
		else
		begin
			if (wr_cfg)
			begin
				hnum_reg <= hwdata[hxip_pkg::CFG_HNUM_LSB +: 8];
				max_reg <= hwdata[hxip_pkg::CFG_MAX_LSB +: 8];
				hval_reg <= hwdata[hxip_pkg::CFG_HVAL_BIT];
				ien_reg <= hwdata[hxip_pkg::CFG_IEN_BIT];
			end
			if (wr_mon)
			begin
				bp_mon_lo <= hwdata[15:0];
				bp_mon_hi <= hwdata[hxip_pkg::MON_HI_LSB +: 16];
			end
			if (wr_put)
			begin
				put_reg <= hwdata[15:0];
			end
		end
	end

	// ------------------------------------------------------------
	// transfer sequencer
	// ------------------------------------------------------------
	hxip_pkg::hxip_state_t state_reg;
	hxip_pkg::hxip_cmd_t kind_reg;
	hxip_pkg::hxip_cmd_t cmd_code;
	logic [7:0] remain_reg, max_eff, chunk;
	logic stall_reg;
	logic [15:0] get_reg;

	assign cmd_code = hxip_pkg::hxip_cmd_t'(hwdata[3:0]);
	assign max_eff = (max_reg == 8'h00) ? 8'h01 : max_reg;
	assign chunk = (remain_reg > max_eff) ? max_eff : remain_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg <= hxip_pkg::ST_IDLE;
			kind_reg <= hxip_pkg::C_NONE;
			remain_reg <= '0;
			stall_reg <= 1'b0;
			bp_busy <= 1'b0;
			bp_host_rd_req <= 1'b0;
			bp_host_wr_req <= 1'b0;
			bp_put_word <= '0;
			get_reg <= '0;
		end
		else
		begin
			unique case (state_reg)
				hxip_pkg::ST_IDLE:
				begin
					if (wr_cmd)
					begin
						kind_reg <= cmd_code;
						remain_reg <= hwdata[hxip_pkg::CMD_CNT_LSB +: 8];
						case (cmd_code)
							hxip_pkg::C_QWR, hxip_pkg::C_QRD:
							begin
								state_reg <= hxip_pkg::ST_Q_REF;
								stall_reg <= 1'b1;
								bp_busy <= cmd_code == hxip_pkg::C_QRD;
							end
							hxip_pkg::C_DRD, hxip_pkg::C_DWR:
							begin
								state_reg <= hxip_pkg::ST_D_XFER;
								stall_reg <= 1'b1;
							end
							hxip_pkg::C_TRD, hxip_pkg::C_TWR:
							begin
								state_reg <= hxip_pkg::ST_T_WAIT;
								stall_reg <= 1'b1;
							end
							hxip_pkg::C_PUT, hxip_pkg::C_GET:
								state_reg <= hxip_pkg::ST_P_REF;
							default:
								state_reg <= hxip_pkg::ST_IDLE;
						endcase
					end
				end
				hxip_pkg::ST_Q_REF:
				begin
					if (ref_ev)
					begin
						bp_host_rd_req <= kind_reg == hxip_pkg::C_QWR;
						bp_host_wr_req <= kind_reg == hxip_pkg::C_QRD;
						state_reg <= hxip_pkg::ST_Q_WAIT;
					end
				end
				hxip_pkg::ST_Q_WAIT:
				begin
					if (fd_ev)
					begin
						bp_host_rd_req <= 1'b0;
						bp_host_wr_req <= 1'b0;
						bp_busy <= 1'b0;
						stall_reg <= 1'b0;
						state_reg <= hxip_pkg::ST_IDLE;
					end
				end
				hxip_pkg::ST_D_XFER:
				begin
					if (ref_ev && remain_reg == 8'h00)
					begin
						bp_busy <= 1'b0;
						stall_reg <= 1'b0;
						state_reg <= hxip_pkg::ST_IDLE;
					end
					else if (ref_ev)
					begin
						bp_busy <= 1'b1;
						remain_reg <= remain_reg - chunk;
					end
				end
				hxip_pkg::ST_T_WAIT:
				begin
					if (trig_ev)
					begin
						state_reg <= hxip_pkg::ST_T_REF;
					end
				end
				hxip_pkg::ST_T_REF:
				begin
					if (ref_ev)
					begin
						bp_busy <= 1'b1;
						state_reg <= hxip_pkg::ST_T_END;
					end
				end
				hxip_pkg::ST_T_END:
				begin
					if (ref_ev)
					begin
						bp_busy <= 1'b0;
						stall_reg <= 1'b0;
						state_reg <= hxip_pkg::ST_IDLE;
					end
				end
				hxip_pkg::ST_P_REF:
				begin
					if (ref_ev && kind_reg == hxip_pkg::C_PUT)
					begin
						bp_put_word <= put_reg;
					end
					if (ref_ev && kind_reg == hxip_pkg::C_GET)
					begin
						get_reg <= s_in_word;
					end
					if (ref_ev)
					begin
						state_reg <= hxip_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	sequence s_q_raise;
		state_reg == hxip_pkg::ST_Q_REF && ref_ev;
	endsequence
	chk_req_raise: assert property (s_q_raise |=> bp_host_rd_req || bp_host_wr_req)
		else $error("queued request flag not raised at refresh");
	chk_rdreq_source: assert property ($rose(bp_host_rd_req) |-> $past(ref_ev) && kind_reg == hxip_pkg::C_QWR)
		else $error("host-read request raised off refresh");
	chk_req_clear: assert property (state_reg == hxip_pkg::ST_Q_WAIT && fd_ev |=> !bp_host_rd_req && !bp_host_wr_req && !stall_reg)
		else $error("request or stall kept after fd00 transfer");
	chk_qwr_nobusy: assert property (state_reg inside {hxip_pkg::ST_Q_REF, hxip_pkg::ST_Q_WAIT} && kind_reg == hxip_pkg::C_QWR |-> !bp_busy)
		else $error("busy during queued write");
	chk_qrd_busy: assert property (state_reg == hxip_pkg::ST_Q_WAIT && kind_reg == hxip_pkg::C_QRD |-> bp_busy && stall_reg)
		else $error("queued read not busy and stalled");
	chk_chunk_limit: assert property (state_reg == hxip_pkg::ST_D_XFER && ref_ev && remain_reg != 8'h00 |=> remain_reg < $past(remain_reg) && $past(remain_reg) - remain_reg <= max_eff)
		else $error("direct chunk exceeds per-cycle maximum");
	chk_put_free: assert property (state_reg == hxip_pkg::ST_P_REF |-> !stall_reg)
		else $error("single-word command stalled program");

	// ------------------------------------------------------------
	// host interrupts and completion flag
	// ------------------------------------------------------------
	logic ibit_seen_reg, ipend_reg, fail_pend_reg, done_pend_reg;
	logic [7:0] inum_reg;
	logic bit_go, ev_go, hit, fail_set, done_set;
	logic [7:0] ev_num;

	assign bit_go = ref_ev && (ibit_seen_reg || ibit_ev) && !cc_ev;
	assign ev_go = cc_ev || bit_go;
	assign ev_num = cc_ev ? s_cc_num : s_irq_num;
	assign hit = hval_reg && ev_num == hnum_reg;
	assign fail_set = ev_go && !ien_reg;
	assign done_set = wr_irq && hwdata[hxip_pkg::IRQ_DONE_BIT];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ibit_seen_reg <= 1'b0;
			ipend_reg <= 1'b0;
			inum_reg <= '0;
			fail_pend_reg <= 1'b0;
			bp_irq_fail <= 1'b0;
			done_pend_reg <= 1'b0;
			bp_sub_done <= 1'b0;
		end
		else
		begin
			ibit_seen_reg <= !bit_go && (ibit_seen_reg || ibit_ev);
			if (ev_go && ien_reg && hit && !ipend_reg)
			begin
				ipend_reg <= 1'b1;
				inum_reg <= ev_num;
			end
			else if (done_set)
			begin
				ipend_reg <= 1'b0;
			end
			fail_pend_reg <= fail_set || (fail_pend_reg && !ref_ev);
			if (ref_ev)
			begin
				bp_irq_fail <= fail_pend_reg;
			end
			done_pend_reg <= done_set || (done_pend_reg && !ref_ev);
			if (ref_ev && done_pend_reg)
			begin
				bp_sub_done <= !bp_sub_done;
			end
		end
	end

	chk_cc_now: assert property (cc_ev && ien_reg && hit && !ipend_reg |=> ipend_reg && inum_reg == $past(s_cc_num))
		else $error("control-code interrupt not taken at once");
	chk_irq_nomatch: assert property (ev_go && !hit && !ipend_reg |=> !ipend_reg)
		else $error("interrupt taken without matching handler");
	chk_fail_start: assert property ($rose(bp_irq_fail) |-> $past(ref_ev))
		else $error("fail flag rose off refresh");
	chk_fail_scan: assert property (bp_irq_fail && ref_ev && !fail_pend_reg |=> !bp_irq_fail)
		else $error("fail flag held beyond one scan");
	chk_done_toggle: assert property (ref_ev && done_pend_reg |=> bp_sub_done != $past(bp_sub_done))
		else $error("completion flag not inverted");
	chk_done_refresh: assert property (!ref_ev |=> $stable(bp_sub_done))
		else $error("completion flag moved off refresh");

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	always_comb
	begin
		rd_mux = '0;
		if (haddr[hxip_pkg::SM_SEL_BIT])
		begin
			rd_mux = {16'h0000, smp_a.rdata};
		end
		else
		begin
			case (haddr[8:0])
				hxip_pkg::OFF_CMD: rd_mux = {24'h00_0000, remain_reg};
				hxip_pkg::OFF_CFG: rd_mux = {14'h0000, ien_reg, hval_reg, max_reg, hnum_reg};
				hxip_pkg::OFF_MON: rd_mux = {bp_mon_hi, bp_mon_lo};
				hxip_pkg::OFF_PUT: rd_mux = {16'h0000, put_reg};
				hxip_pkg::OFF_GET: rd_mux = {16'h0000, get_reg};
				hxip_pkg::OFF_IRQ: rd_mux = {23'h00_0000, ipend_reg, inum_reg};
				hxip_pkg::OFF_STAT: rd_mux = {16'h0000, bp_host_wr_req, bp_host_rd_req,
					6'h00, bp_irq_fail, bp_sub_done, bp_busy, stall_reg, 1'b0, state_reg};
				default: rd_mux = '0;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: test/hxip_host_model.sv */
/*
 host cpu model on the backplane pins: free scan, strobes, fd00 answers.
 assumes its tasks are called just after a rising hclk edge.
*/
`timescale 1ns/1ns
`default_nettype none
module hxip_host_model (
	input wire logic hclk,
	input wire logic bp_host_rd_req,
	input wire logic bp_host_wr_req,
	output logic bp_refresh,
	output logic bp_irq_bit,
	output logic [7:0] bp_irq_num,
	output logic bp_cc_stb,
	output logic [7:0] bp_cc_num,
	output logic bp_fd_done,
	output logic bp_trig,
	output logic bp_sm_wr,
	output logic [5:0] bp_sm_addr,
	output logic [15:0] bp_sm_wdata
);
	logic [4:0] stb = 5'h00;
	int ph = 0;
	assign {bp_irq_bit, bp_cc_stb, bp_fd_done, bp_trig, bp_sm_wr} = stb;
	// scan: refresh high 4 of every 16 cycles
	assign bp_refresh = (ph < 4);
	initial {bp_irq_num, bp_cc_num, bp_sm_addr, bp_sm_wdata} = '0;
	always @(posedge hclk)
		ph <= (ph + 1) % 16;
	// data settles 3 clocks, strobe high 4, then low 3
	task automatic fire(input int k);
		repeat (3) @(posedge hclk);
		stb[k] <= 1'b1;
		repeat (4) @(posedge hclk);
		stb[k] <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask
	task automatic cc_irq(input logic [7:0] n);
		bp_cc_num <= n;
		fire(3);
		bp_cc_num <= ~n;
	endtask
	task automatic bit_irq(input logic [7:0] n);
		bp_irq_num <= n;
		fire(4);
		// number stands until a refresh has taken the bit
		@(posedge bp_refresh);
		repeat (4) @(posedge hclk);
		bp_irq_num <= ~n;
	endtask
	task automatic sm_write(input logic [5:0] a, input logic [15:0] v);
		bp_sm_addr <= a;
		bp_sm_wdata <= v;
		fire(0);
		bp_sm_wdata <= ~v;
	endtask
	task automatic sm_read(input logic [5:0] a);
		bp_sm_addr <= a;
		repeat (4) @(posedge hclk);
	endtask
	// one fd00 answer per raised request
	initial forever
	begin
		@(posedge hclk);
		if (bp_host_rd_req === 1'b1 || bp_host_wr_req === 1'b1)
			fire(2);
	end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
/*
 bench of the host exchange port: registers, queued, direct, triggered,
 single-word, shared-memory and interrupt sequences over ahb-lite.
 assumes hxip_host_model stands in for the host cpu.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [15:0] bp_in_word = 16'h0000;
	logic [31:0] d, hrdata;
	logic hreadyout, hresp, bp_refresh, bp_irq_bit, bp_cc_stb, bp_fd_done, bp_trig, old;
	logic bp_sm_wr, bp_host_rd_req, bp_host_wr_req, bp_irq_fail, bp_busy, bp_sub_done;
	logic [7:0] bp_irq_num, bp_cc_num;
	logic [5:0] bp_sm_addr;
	logic [15:0] bp_sm_wdata, bp_sm_rdata, bp_put_word, bp_mon_lo, bp_mon_hi;
	int fail_count = 0;
	int checked = 0;
	int cyc = 0;
	int rem[3] = '{3, 1, 0};
	always #50 hclk = ~hclk;
	hxip_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .bp_refresh, .bp_irq_bit,
		.bp_irq_num, .bp_cc_stb, .bp_cc_num, .bp_fd_done, .bp_trig, .bp_sm_wr, .bp_sm_addr,
		.bp_sm_wdata, .bp_in_word, .bp_sm_rdata, .bp_put_word, .bp_mon_lo, .bp_mon_hi,
		.bp_host_rd_req, .bp_host_wr_req, .bp_irq_fail, .bp_busy, .bp_sub_done);
	hxip_host_model i_host (.hclk, .bp_host_rd_req, .bp_host_wr_req, .bp_refresh,
		.bp_irq_bit, .bp_irq_num, .bp_cc_stb, .bp_cc_num, .bp_fd_done, .bp_trig,
		.bp_sm_wr, .bp_sm_addr, .bp_sm_wdata);
	// ----------
	// tasks
	// ----------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic ahb(input logic w, input logic [8:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		hsize <= 3'h2;
		haddr <= 32'(a);
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		d = hrdata;
		hsel <= 1'b0;
	endtask
	task automatic rc(input logic [8:0] a, input logic [31:0] m, input logic [31:0] e);
		ahb(1'b0, a, 32'h0000_0000);
		chk(d & m, e);
	endtask
	task automatic scan();
		@(posedge bp_refresh);
		repeat (5) @(posedge hclk);
	endtask
	task automatic await(input logic v);
		for (int i = 0; i < 200 && (bp_host_rd_req | bp_host_wr_req) !== v; i++)
			@(posedge hclk);
	endtask
	task automatic cc_try(input logic [31:0] e);
		fork
			i_host.cc_irq(8'h02);
			begin
				repeat (8) @(posedge hclk);
				rc(hxip_pkg::OFF_IRQ, '1, e);
			end
		join
	endtask
	task automatic done_chk();
		old = bp_sub_done;
		ahb(1'b1, hxip_pkg::OFF_IRQ, 32'h0000_0001);
		// pending drops, last taken number stays readable
		rc(hxip_pkg::OFF_IRQ, '1, 32'h0000_0002);
		scan();
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 4000)
		begin
			fail_count++;
			finish_test();
		end
	end
	// ----------
	// tests
	// ----------
	initial
	begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		rc(hxip_pkg::OFF_CFG, '1, 32'h0002_7F00);
		ahb(1'b1, 9'h01C, 32'hFFFF_FFFF);
		rc(9'h01C, '1, 32'h0000_0000);
		ahb(1'b1, hxip_pkg::OFF_MON, 32'h5678_1234);
		repeat (2) @(posedge hclk);
		chk({bp_mon_hi, bp_mon_lo}, 32'h5678_1234);
		chk(32'({bp_host_wr_req, bp_host_rd_req}), 32'h0000_0000);
		i_host.sm_write(6'h05, 16'hA55A);
		rc(9'h114, '1, 32'h0000_A55A);
		ahb(1'b1, 9'h118, 32'h0000_3C3C);
		i_host.sm_read(6'h06);
		chk(32'(bp_sm_rdata), 32'h0000_3C3C);
		chk(32'({hresp, hreadyout}), 32'h0000_0001);
		$display("test registers done");
		scan();
		ahb(1'b1, hxip_pkg::OFF_CMD, 32'h0000_0001);
		rc(hxip_pkg::OFF_STAT, 32'hFFFF_FFF8, 32'h0000_0010);
		await(1'b1);
		chk(32'({bp_host_rd_req, bp_busy}), 32'h0000_0002);
		rc(hxip_pkg::OFF_STAT, 32'hFFFF_FFF8, 32'h0000_4010);
		await(1'b0);
		rc(hxip_pkg::OFF_STAT, 32'h0000_C010, 32'h0000_0000);
		scan();
		ahb(1'b1, hxip_pkg::OFF_CMD, 32'h0000_0002);
		await(1'b1);
		chk(32'({bp_host_wr_req, bp_busy}), 32'h0000_0003);
		rc(hxip_pkg::OFF_STAT, 32'hFFFF_FFF8, 32'h0000_8030);
		await(1'b0);
		rc(hxip_pkg::OFF_STAT, 32'h0000_C010, 32'h0000_0000);
		$display("test queued done");
		ahb(1'b1, hxip_pkg::OFF_CFG, 32'h0002_0200);
		scan();
		ahb(1'b1, hxip_pkg::OFF_CMD, 32'h0000_0503);
		for (int i = 0; i < 3; i++)
		begin
			scan();
			rc(hxip_pkg::OFF_CMD, 32'h0000_00FF, 32'(rem[i]));
			chk(32'(bp_busy), 32'h0000_0001);
		end
		scan();
		rc(hxip_pkg::OFF_STAT, 32'h0000_0030, 32'h0000_0000);
		for (int c = 4; c < 7; c++)
		begin
			scan();
			ahb(1'b1, hxip_pkg::OFF_CMD, 32'h0000_0100 | c);
			fork
				if (c > 4) i_host.fire(1);
				scan();
			join
			chk(32'(bp_busy), 32'h0000_0001);
			scan();
			rc(hxip_pkg::OFF_STAT, 32'h0000_0030, 32'h0000_0000);
		end
		$display("test direct and triggered done");
		scan();
		ahb(1'b1, hxip_pkg::OFF_PUT, 32'h0000_1234);
		ahb(1'b1, hxip_pkg::OFF_CMD, 32'h0000_0007);
		rc(hxip_pkg::OFF_STAT, 32'h0000_0010, 32'h0000_0000);
		scan();
		chk(32'(bp_put_word), 32'h0000_1234);
		bp_in_word <= 16'hBEEF;
		ahb(1'b1, hxip_pkg::OFF_CMD, 32'h0000_0008);
		scan();
		rc(hxip_pkg::OFF_GET, '1, 32'h0000_BEEF);
		$display("test put and get done");
		ahb(1'b1, hxip_pkg::OFF_CFG, 32'h0003_7F02);
		i_host.sm_write(6'h09, 16'h0F0F);
		scan();
		cc_try(32'h0000_0102);
		rc(9'h124, '1, 32'h0000_0F0F);
		done_chk();
		chk({31'h0000_0000, bp_sub_done}, {31'h0000_0000, ~old});
		i_host.bit_irq(8'h03);
		scan();
		rc(hxip_pkg::OFF_IRQ, '1, 32'h0000_0002);
		i_host.bit_irq(8'h02);
		scan();
		rc(hxip_pkg::OFF_IRQ, '1, 32'h0000_0102);
		done_chk();
		chk({31'h0000_0000, bp_sub_done}, {31'h0000_0000, ~old});
		$display("test interrupts done");
		ahb(1'b1, hxip_pkg::OFF_CFG, 32'h0001_7F02);
		scan();
		fork
			i_host.cc_irq(8'h02);
			scan();
		join
		chk(32'(bp_irq_fail), 32'h0000_0001);
		scan();
		chk(32'(bp_irq_fail), 32'h0000_0000);
		ahb(1'b1, hxip_pkg::OFF_CFG, 32'h0003_7F02);
		scan();
		cc_try(32'h0000_0102);
		$display("test interrupt refusal done");
		finish_test();
	end
endmodule
`default_nettype wire
